// ==== cmt_data_mem.sv ====
// Purpose: Behavioural banked data memory facing the execute unit.
// Assumes: Read data is captured on the edge ending the read strobe cycle.
// Notes: Outside its valid cycle the read data toggles, so a late sample is caught.
module cmt_data_mem (
   input wire logic core_clk_i,
   input wire logic [11:0] mem_addr_i,
   input wire logic mem_re_i,
   input wire logic mem_we_i,
   input wire logic [7:0] mem_wdata_i,
   output logic [7:0] mem_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:4095];

   // Whole space starts cleared so tests know every byte
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'h00;
      end
      mem_rdata_o = 8'h00;
   end

   // Write on the strobe; read data holds only one cycle, then inverts
   always @(posedge core_clk_i) begin
      if (mem_we_i) begin
         mem[mem_addr_i] <= mem_wdata_i;
      end
      if (mem_re_i) begin
         mem_rdata_o <= mem[mem_addr_i];
      end else begin
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule

// ==== cmt_exec.sv ====
// Purpose: Execute unit for literal load, store, move, test-and-skip, XOR literal, indexed copy and push.
// Assumes: Fetch presents each word on instr_i during phase Q1; data memory reads with one clock latency.
// Notes: Opcodes outside this group pass as no-operations here.

// Function
// - Load literal into accumulator in one cycle, flags untouched.
// - Store accumulator into addressed register in one cycle, flags untouched.
// - Register operand is eight bits reaching any byte of the bank.
// - Access bit 0 with extension on: operands up to 5Fh index pointer two.
// - Test-and-skip on zero discards the next word, taking two cycles, or three when that word is two-word.
// - XOR literal into accumulator, updating negative and zero flags.
// - Push literal writes immediate at pointer two address in one cycle.
// - After push, pointer two decrements by one, flags untouched.
// - Move register to accumulator or back to register, updating negative and zero.
// - Access bit 0 uses access bank; 1 uses bank select register.
module cmt_exec (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [15:0] instr_i,
   input wire logic ext_en_i,
   input wire logic [3:0] bank_sel_i,
   input wire logic ptr_load_i,
   input wire logic [11:0] ptr_load_val_i,
   input wire logic [7:0] mem_rdata_i,
   output logic [1:0] phase_o,
   output logic [11:0] mem_addr_o,
   output logic mem_re_o,
   output logic mem_we_o,
   output logic [7:0] mem_wdata_o,
   output logic [7:0] acc_o,
   output logic neg_flag_o,
   output logic zero_flag_o,
   output logic [11:0] ptr_two_o,
   output logic discard_o
);
   // ***********************************************
   // Helpers
   // ***********************************************
   // One-hot decode of an instruction word
   function automatic logic [cmt_pkg::OPB_COUNT-1:0] decode(input logic [15:0] w);
      logic [cmt_pkg::OPB_COUNT-1:0] d;
      d = '0;
      d[cmt_pkg::OPB_LOAD] = (w[15:8] == cmt_pkg::OPC_LOAD_LIT);
      d[cmt_pkg::OPB_XOR] = (w[15:8] == cmt_pkg::OPC_XOR_LIT);
      d[cmt_pkg::OPB_PUSH] = (w[15:8] == cmt_pkg::OPC_PUSH_LIT);
      d[cmt_pkg::OPB_STORE] = (w[15:9] == cmt_pkg::OPC_STORE_ACC);
      d[cmt_pkg::OPB_TEST] = (w[15:9] == cmt_pkg::OPC_TEST_SKIP);
      d[cmt_pkg::OPB_MOVE] = (w[15:10] == cmt_pkg::OPC_MOVE_REG);
      d[cmt_pkg::OPB_COPY] = (w[15:7] == cmt_pkg::OPC_COPY_FIRST);
      return d;
   endfunction

   // Words that carry a second word behind them
   function automatic logic two_word(input logic [15:0] w);
      return (w[15:12] == cmt_pkg::OPC_TWO_A) || (w[15:10] == cmt_pkg::OPC_TWO_B);
   endfunction

   // Register operand address: indexed, access bank or selected bank
   function automatic logic [11:0] reg_addr(input logic [7:0] f, input logic a, input logic [3:0] bank_select_reg,
                                            input logic [11:0] ptr, input logic ext);
      logic [7:0] split;
      split = ext ? cmt_pkg::ACC_SPLIT_EXT : cmt_pkg::ACC_SPLIT_STD;
      if (a) begin
         return {bank_select_reg, f};
      end else if (ext && (f <= cmt_pkg::INDEX_MAX)) begin
         return ptr + {4'h0, f};
      end else if (f < split) begin
         return {cmt_pkg::ACC_LOW_BANK, f};
      end else begin
         return {cmt_pkg::ACC_HIGH_BANK, f};
      end
   endfunction

   // ***********************************************
   // State
   // ***********************************************
   logic [1:0] phase_reg;
   logic [15:0] ir_reg;
   logic [7:0] opnd_reg;
   logic [7:0] acc_reg;
   logic neg_reg;
   logic zero_reg;
   logic [11:0] ptr_reg;
   cmt_pkg::cmt_mode_t mode_reg;
   logic discard_reg;
   logic [cmt_pkg::OPB_COUNT-1:0] dec_in;
   logic [cmt_pkg::OPB_COUNT-1:0] dec_ir;
   logic exec;
   logic [7:0] xor_next;

   assign dec_in = decode(instr_i);
   assign dec_ir = decode(ir_reg);
   assign exec = (mode_reg == cmt_pkg::MD_EXEC);
   assign xor_next = acc_reg ^ ir_reg[7:0];

   // Phase divider: Q1..Q4 repeat forever
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         phase_reg <= cmt_pkg::PH_Q1;
      end else begin
         phase_reg <= phase_reg + 2'h1;
      end
   end

   // Instruction capture at the end of Q1
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ir_reg <= 16'h0000;
      end else if (phase_reg == cmt_pkg::PH_Q1) begin
         ir_reg <= instr_i;
      end
   end

   // ***********************************************
   // Sequencing of skips and second words
   // ***********************************************
   // Mode only changes at the cycle boundary so every word sees a whole cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mode_reg <= cmt_pkg::MD_EXEC;
      end else if (phase_reg == cmt_pkg::PH_Q4) begin
         case (mode_reg)
            cmt_pkg::MD_EXEC: begin
               if (dec_ir[cmt_pkg::OPB_TEST] && (opnd_reg == 8'h00)) begin
                  mode_reg <= cmt_pkg::MD_SKIP1;
               end else if (dec_ir[cmt_pkg::OPB_COPY]) begin
                  mode_reg <= cmt_pkg::MD_COPY2;
               end else begin
                  mode_reg <= cmt_pkg::MD_EXEC;
               end
            end
            cmt_pkg::MD_SKIP1: begin
               mode_reg <= two_word(ir_reg) ? cmt_pkg::MD_SKIP2 : cmt_pkg::MD_EXEC;
            end
            default: begin
               mode_reg <= cmt_pkg::MD_EXEC;
            end
         endcase
      end
   end

   // Discard level follows the skip modes from its own flop, so the pin never glitches on a decode
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         discard_reg <= 1'b0;
      end else if (phase_reg == cmt_pkg::PH_Q4) begin
         discard_reg <= (exec && dec_ir[cmt_pkg::OPB_TEST] && (opnd_reg == 8'h00)) ||
                        ((mode_reg == cmt_pkg::MD_SKIP1) && two_word(ir_reg));
      end
   end

   // ***********************************************
   // Data memory port
   // ***********************************************
   // Address and read strobe go out at end of Q1 so read data lands in Q3
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mem_addr_o <= 12'h000;
         mem_re_o <= 1'b0;
      end else if (phase_reg == cmt_pkg::PH_Q1) begin
         mem_re_o <= 1'b0;
         if (mode_reg == cmt_pkg::MD_COPY2) begin
            mem_addr_o <= ptr_reg + {5'h00, instr_i[6:0]};
         end else if (exec && dec_in[cmt_pkg::OPB_PUSH]) begin
            mem_addr_o <= ptr_reg;
         end else if (exec && dec_in[cmt_pkg::OPB_COPY]) begin
            mem_addr_o <= ptr_reg + {5'h00, instr_i[6:0]};
            mem_re_o <= 1'b1;
         end else if (exec && (dec_in[cmt_pkg::OPB_STORE] || dec_in[cmt_pkg::OPB_TEST] ||
                               dec_in[cmt_pkg::OPB_MOVE])) begin
            mem_addr_o <= reg_addr(instr_i[7:0], instr_i[8], bank_sel_i, ptr_reg, ext_en_i);
            mem_re_o <= !dec_in[cmt_pkg::OPB_STORE];
         end
      end else begin
         mem_re_o <= 1'b0;
      end
   end

   // Operand capture in Q3; copy keeps it across into the second word
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         opnd_reg <= 8'h00;
      end else if ((phase_reg == cmt_pkg::PH_Q3) && exec) begin
         opnd_reg <= mem_rdata_i;
      end
   end

   // Write strobe is high during Q4 only; the memory commits on the Q4 edge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         mem_we_o <= 1'b0;
         mem_wdata_o <= 8'h00;
      end else if (phase_reg == cmt_pkg::PH_Q3) begin
         mem_we_o <= 1'b0;
         if (mode_reg == cmt_pkg::MD_COPY2) begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= opnd_reg;
         end else if (exec && dec_ir[cmt_pkg::OPB_STORE]) begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= acc_reg;
         end else if (exec && dec_ir[cmt_pkg::OPB_PUSH]) begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= ir_reg[7:0];
         end else if (exec && dec_ir[cmt_pkg::OPB_MOVE] && ir_reg[9]) begin
            mem_we_o <= 1'b1;
            mem_wdata_o <= mem_rdata_i;
         end
      end else begin
         mem_we_o <= 1'b0;
      end
   end

   // ***********************************************
   // Accumulator, flags and pointer two
   // ***********************************************
   // Results retire at the end of Q4; load and store never touch the flags
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         acc_reg <= cmt_pkg::ACC_RESET;
         neg_reg <= 1'b0;
         zero_reg <= 1'b0;
      end else if ((phase_reg == cmt_pkg::PH_Q4) && exec) begin
         if (dec_ir[cmt_pkg::OPB_LOAD]) begin
            acc_reg <= ir_reg[7:0];
         end else if (dec_ir[cmt_pkg::OPB_XOR]) begin
            acc_reg <= xor_next;
            neg_reg <= xor_next[7];
            zero_reg <= (xor_next == 8'h00);
         end else if (dec_ir[cmt_pkg::OPB_MOVE]) begin
            if (!ir_reg[9]) begin
               acc_reg <= opnd_reg;
            end
            neg_reg <= opnd_reg[7];
            zero_reg <= (opnd_reg == 8'h00);
         end
      end
   end

   // External loads win; a push in the same cycle is lost, which other logic must avoid
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ptr_reg <= cmt_pkg::PTR_RESET;
      end else if (ptr_load_i) begin
         ptr_reg <= ptr_load_val_i;
      end else if ((phase_reg == cmt_pkg::PH_Q4) && exec && dec_ir[cmt_pkg::OPB_PUSH]) begin
         ptr_reg <= ptr_reg - 12'h001;
      end
   end

   // Outputs straight from flip-flops
   assign phase_o = phase_reg;
   assign acc_o = acc_reg;
   assign neg_flag_o = neg_reg;
   assign zero_flag_o = zero_reg;
   assign ptr_two_o = ptr_reg;
   assign discard_o = discard_reg;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_retire(int b);
      (phase_reg == cmt_pkg::PH_Q4) && exec && dec_ir[b];
   endsequence
   sequence s_skip_start;
      s_retire(cmt_pkg::OPB_TEST) ##0 (opnd_reg == 8'h00);
   endsequence
   sequence s_copy_read;
      (phase_reg == cmt_pkg::PH_Q1) && exec && dec_in[cmt_pkg::OPB_COPY] && !ptr_load_i;
   endsequence

   load_literal_a: assert property (s_retire(cmt_pkg::OPB_LOAD) |=>
      (acc_reg == $past(ir_reg[7:0])) && $stable(neg_reg) && $stable(zero_reg))
      else $error("load literal result wrong");
   store_write_a: assert property ((phase_reg == cmt_pkg::PH_Q3) && exec && dec_ir[cmt_pkg::OPB_STORE] |=>
      mem_we_o && (mem_wdata_o == acc_reg) ##1 !mem_we_o && $stable(neg_reg))
      else $error("store accumulator write wrong");
   bank_addr_a: assert property ((phase_reg == cmt_pkg::PH_Q1) && exec && dec_in[cmt_pkg::OPB_TEST] &&
      instr_i[8] |=> mem_addr_o == {$past(bank_sel_i), $past(instr_i[7:0])})
      else $error("banked address wrong");
   indexed_addr_a: assert property ((phase_reg == cmt_pkg::PH_Q1) && exec && dec_in[cmt_pkg::OPB_MOVE] &&
      !instr_i[8] && ext_en_i && (instr_i[7:0] <= 8'h5f) |=> mem_addr_o == $past(ptr_reg) + {4'h0, $past(instr_i[7:0])})
      else $error("indexed address wrong");
   skip_taken_a: assert property (s_skip_start |=> discard_o [*4])
      else $error("taken skip did not discard");
   skip_two_word_a: assert property ((phase_reg == cmt_pkg::PH_Q4) && (mode_reg == cmt_pkg::MD_SKIP1) &&
      two_word(ir_reg) |=> discard_o [*4] ##1 !discard_o)
      else $error("two-word skip length wrong");
   xor_result_a: assert property (s_retire(cmt_pkg::OPB_XOR) |=>
      (acc_reg == $past(xor_next)) && (zero_flag_o == (acc_reg == 8'h00)) && (neg_flag_o == acc_reg[7]))
      else $error("xor literal result wrong");
   push_store_a: assert property ((phase_reg == cmt_pkg::PH_Q1) && exec && dec_in[cmt_pkg::OPB_PUSH] |=>
      (mem_addr_o == $past(ptr_reg)) ##2 mem_we_o && (mem_wdata_o == ir_reg[7:0]))
      else $error("push literal write wrong");
   push_decrement_a: assert property (s_retire(cmt_pkg::OPB_PUSH) ##0 !ptr_load_i |=>
      (ptr_reg == $past(ptr_reg) - 12'h001) && $stable(zero_reg))
      else $error("pointer two not decremented");
   move_result_a: assert property (s_retire(cmt_pkg::OPB_MOVE) ##0 !ir_reg[9] |=>
      (acc_reg == $past(opnd_reg)) && (zero_flag_o == (acc_reg == 8'h00)))
      else $error("move register result wrong");
   copy_flow_a: assert property (s_copy_read |=> mem_re_o ##3 (mode_reg == cmt_pkg::MD_COPY2) ##3
      mem_we_o && (mem_wdata_o == opnd_reg))
      else $error("indexed copy flow wrong");
endmodule

// ==== cmt_pkg.sv ====
// Purpose: Shared constants and types for the move, test and push execute unit.
// Assumes: 16-bit instruction words, 12-bit data addresses, 8-bit data.
// Notes: Four clock phases form one instruction cycle.
package cmt_pkg;
   // ***********************************************
   // Instruction cycle phases
   // ***********************************************
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;

   // ***********************************************
   // Opcode fields
   // ***********************************************
   localparam logic [7:0] OPC_LOAD_LIT = 8'h0e;   // instr[15:8]
   localparam logic [7:0] OPC_XOR_LIT = 8'h0a;    // instr[15:8]
   localparam logic [7:0] OPC_PUSH_LIT = 8'hfa;   // instr[15:8]
   localparam logic [6:0] OPC_STORE_ACC = 7'h37;  // instr[15:9]
   localparam logic [6:0] OPC_TEST_SKIP = 7'h33;  // instr[15:9]
   localparam logic [5:0] OPC_MOVE_REG = 6'h14;   // instr[15:10]
   localparam logic [8:0] OPC_COPY_FIRST = 9'h1d7; // instr[15:7]
   localparam logic [3:0] OPC_TWO_A = 4'hc;       // instr[15:12]
   localparam logic [5:0] OPC_TWO_B = 6'h3b;      // instr[15:10]

   // ***********************************************
   // Decoded operation bit positions
   // ***********************************************
   localparam int OPB_LOAD = 0;
   localparam int OPB_XOR = 1;
   localparam int OPB_PUSH = 2;
   localparam int OPB_STORE = 3;
   localparam int OPB_TEST = 4;
   localparam int OPB_MOVE = 5;
   localparam int OPB_COPY = 6;
   localparam int OPB_COUNT = 7;

   // ***********************************************
   // Addressing constants and reset values
   // ***********************************************
   localparam logic [7:0] INDEX_MAX = 8'h5f;
   localparam logic [7:0] ACC_SPLIT_STD = 8'h80;
   localparam logic [7:0] ACC_SPLIT_EXT = 8'h60;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;

   typedef enum logic [3:0] {
      MD_EXEC = 4'b0001,
      MD_SKIP1 = 4'b0010,
      MD_SKIP2 = 4'b0100,
      MD_COPY2 = 4'b1000
   } cmt_mode_t;
endpackage

// ==== cpu_move_test_push_ops_tb.sv ====
// Purpose: Self-checking bench for the move, test and push execute unit.
// Assumes: One instruction word per four clocks, driven 1 ns after the edge.
// Notes: Tests run in order and rely on the state left by earlier ones.
module cpu_move_test_push_ops_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, ext = 1'b0, pld = 1'b0, disc;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank = 4'h3;
   logic [11:0] pval = 12'h000, addr, ptr;
   logic [7:0] rdata, wdata, acc;
   logic [1:0] phase;
   logic re, we, neg, zero, dsc;
   int bad_count = 0, num_checks = 0;

   // ***********************************************
   // Clock, unit and memory
   // ***********************************************
   always #5 clk = ~clk;
   cmt_exec DUT (.core_clk_i(clk), .rst_i(rst), .instr_i(instr), .ext_en_i(ext), .bank_sel_i(bank),
      .ptr_load_i(pld), .ptr_load_val_i(pval), .mem_rdata_i(rdata), .phase_o(phase), .mem_addr_o(addr),
      .mem_re_o(re), .mem_we_o(we), .mem_wdata_o(wdata), .acc_o(acc), .neg_flag_o(neg),
      .zero_flag_o(zero), .ptr_two_o(ptr), .discard_o(dsc));
   cmt_data_mem u_mem (.core_clk_i(clk), .mem_addr_i(addr), .mem_re_i(re), .mem_we_i(we),
      .mem_wdata_i(wdata), .mem_rdata_o(rdata));

   // ***********************************************
   // Instruction builders and drivers
   // ***********************************************
   function automatic logic [15:0] ld(input logic [7:0] k);
      return {cmt_pkg::OPC_LOAD_LIT, k};
   endfunction
   function automatic logic [15:0] xl(input logic [7:0] k);
      return {cmt_pkg::OPC_XOR_LIT, k};
   endfunction
   function automatic logic [15:0] pu(input logic [7:0] k);
      return {cmt_pkg::OPC_PUSH_LIT, k};
   endfunction
   function automatic logic [15:0] st(input logic a, input logic [7:0] f);
      return {cmt_pkg::OPC_STORE_ACC, a, f};
   endfunction
   function automatic logic [15:0] ts(input logic a, input logic [7:0] f);
      return {cmt_pkg::OPC_TEST_SKIP, a, f};
   endfunction
   function automatic logic [15:0] mv(input logic d, input logic a, input logic [7:0] f);
      return {cmt_pkg::OPC_MOVE_REG, d, a, f};
   endfunction
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // One instruction cycle; disc records whether the word was thrown away
   task automatic run(input logic [15:0] w);
      instr = w;
      disc = 1'b0;
      for (int i = 0; i < 4; i++) begin
         disc = disc | dsc;
         step();
      end
   endtask
   // Pointer load rides on a no-operation cycle
   task automatic load_ptr(input logic [11:0] v);
      instr = 16'h0000;
      pld = 1'b1;
      pval = v;
      step();
      pld = 1'b0;
      repeat (3) step();
   endtask
   task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_a(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_f(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_literal();
      run(ld(8'hb5));
      chk_b(acc, 8'hb5);
      chk_f(zero, 1'b0);
      run(xl(8'haf));
      chk_b(acc, 8'h1a);
      chk_f(neg, 1'b0);
      run(xl(8'h1a));
      chk_b(acc, 8'h00);
      chk_f(zero, 1'b1);
      run(ld(8'h80));
      chk_b(acc, 8'h80);
      chk_f(zero, 1'b1);
      chk_f(neg, 1'b0);
      run(xl(8'h00));
      chk_f(neg, 1'b1);
      chk_f(zero, 1'b0);
      $display("t_literal done");
   endtask
   task automatic t_store_move();
      run(ld(8'h4f));
      run(st(1'b1, 8'hff));
      chk_b(u_mem.mem[12'h3ff], 8'h4f);
      chk_f(neg, 1'b1);
      run(st(1'b0, 8'h10));
      chk_b(u_mem.mem[12'h010], 8'h4f);
      run(st(1'b0, 8'h90));
      chk_b(u_mem.mem[12'hf90], 8'h4f);
      run(ld(8'h00));
      run(mv(1'b0, 1'b1, 8'hff));
      chk_b(acc, 8'h4f);
      chk_f(neg, 1'b0);
      run(mv(1'b1, 1'b1, 8'h00));
      chk_b(acc, 8'h4f);
      chk_f(zero, 1'b1);
      chk_b(u_mem.mem[12'h300], 8'h00);
      $display("t_store_move done");
   endtask
   // Extension on: small operands index pointer two, the rest split at 60h
   task automatic t_indexed();
      ext = 1'b1;
      load_ptr(12'h1f0);
      run(ld(8'h77));
      run(st(1'b0, 8'h20));
      chk_b(u_mem.mem[12'h210], 8'h77);
      run(st(1'b0, 8'h5f));
      chk_b(u_mem.mem[12'h24f], 8'h77);
      run(st(1'b0, 8'h60));
      chk_b(u_mem.mem[12'hf60], 8'h77);
      ext = 1'b0;
      $display("t_indexed done");
   endtask
   task automatic t_skip();
      run(ld(8'h11));
      run(ts(1'b1, 8'h00));
      run(ld(8'h22));
      chk_f(disc, 1'b1);
      chk_b(acc, 8'h11);
      run(ld(8'h33));
      chk_f(disc, 1'b0);
      chk_b(acc, 8'h33);
      run(ts(1'b1, 8'hff));
      run(ld(8'h44));
      chk_f(disc, 1'b0);
      chk_b(acc, 8'h44);
      run(ts(1'b1, 8'h00));
      run(16'hc000);
      chk_f(disc, 1'b1);
      run(ld(8'h55));
      chk_f(disc, 1'b1);
      chk_b(acc, 8'h44);
      run(ld(8'h66));
      chk_f(disc, 1'b0);
      chk_b(acc, 8'h66);
      $display("t_skip done");
   endtask
   task automatic t_push();
      load_ptr(12'h1ec);
      run(pu(8'h08));
      chk_b(u_mem.mem[12'h1ec], 8'h08);
      chk_a(ptr, 12'h1eb);
      run(pu(8'h09));
      chk_b(u_mem.mem[12'h1eb], 8'h09);
      chk_a(ptr, 12'h1ea);
      chk_f(zero, 1'b1);
      load_ptr(12'h000);
      run(pu(8'ha5));
      chk_b(u_mem.mem[12'h000], 8'ha5);
      chk_a(ptr, 12'hfff);
      $display("t_push done");
   endtask
   task automatic t_copy();
      bank = 4'h0;
      run(ld(8'h33));
      run(st(1'b1, 8'h85));
      load_ptr(12'h080);
      run(16'heb85);
      run(16'hf006);
      chk_b(u_mem.mem[12'h086], 8'h33);
      run(16'heb85);
      run(16'hf07f);
      chk_b(u_mem.mem[12'h0ff], 8'h33);
      chk_a(ptr, 12'h080);
      chk_f(zero, 1'b1);
      $display("t_copy done");
   endtask

   // ***********************************************
   // Sequence, verdict and watchdog
   // ***********************************************
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      chk_b(acc, 8'h00);
      chk_a(ptr, 12'h000);
      chk_b({6'h00, phase}, 8'h00);
      t_literal();
      t_store_move();
      t_indexed();
      t_skip();
      t_push();
      t_copy();
      close_out();
   end
   // Roughly 40 instructions of 4 cycles; a wide margin covers a stall
   initial begin
      #20000;
      bad_count++;
      close_out();
   end
endmodule
